//--- core/rcla_pkg.sv
package rcla_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int          ADDR_W      = 8;
    localparam logic [7:0]  OFF_CMD     = 8'h00;
    localparam logic [7:0]  OFF_CFG     = 8'h04;
    localparam logic [7:0]  OFF_BITDIV  = 8'h08;
    localparam logic [7:0]  OFF_STATUS  = 8'h0c;

    // Command bits, write one to trigger, read as zero
    localparam int CMD_LEV_POS = 0;
    localparam int CMD_BC_POS  = 1;
    localparam int CMD_SFH_POS = 2;
    localparam int CMD_SFS_POS = 3;

    // Configuration fields
    localparam int          CFG_LEV_POS   = 0;
    localparam int          CFG_BW_POS    = 4;
    localparam logic [1:0]  CFG_LEV_RESET = 2'h0;
    localparam logic [1:0]  CFG_BW_RESET  = 2'h2;

    // ----------------------------------------------------------------
    // Encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] LEV_LOSSY   = 2'h0;
    localparam logic [1:0] LEV_PEAK    = 2'h1;
    localparam logic [1:0] LEV_AVERAGE = 2'h2;
    localparam logic [1:0] LEV_HOLD    = 2'h3;
    localparam logic [2:0] LVL_CLAMP   = 3'h4;
    localparam logic [1:0] BW_WIDE     = 2'h0;
    localparam logic [1:0] BW_MEDIUM   = 2'h1;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int          REF_CLK_HZ     = 125_000_000;
    localparam int          BIT_RATE_HZ    = 8_000;
    localparam int          BIT_DIV_W      = 16;
    localparam int          BIT_CLKS_RESET = REF_CLK_HZ / BIT_RATE_HZ;
    localparam logic [15:0] BIT_DIV_MIN    = 16'h0002;
    localparam int          BIT_CNT_W      = 6;
    localparam logic [5:0]  LEV_CLAMP_BITS = 6'h01;
    localparam logic [5:0]  LEV_SRCH_BITS  = 6'h1c;
    localparam logic [5:0]  LEV_RESID_BITS = 6'h1e;
    localparam logic [5:0]  BC_SRCH_BITS   = 6'h0e;
    localparam logic [5:0]  BC_WIDE_BITS   = 6'h10;
    localparam logic [5:0]  BC_MED_BITS    = 6'h1e;
    localparam logic [5:0]  CNT_MAX        = 6'h3f;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {LS_RESID, LS_CLAMP, LS_LOSSY} rcla_lev_state_t;
    typedef enum logic [1:0] {BS_RESID, BS_WIDE, BS_MEDIUM} rcla_bc_state_t;

    typedef struct packed {
        logic [1:0] bc_phase;
        logic       bc_search;
        logic [1:0] lev_phase;
        logic       lev_search;
        logic [1:0] loop_bw;
        logic [2:0] level_mode;
    } rcla_status_t;

endpackage

//--- core/rcla_top.sv
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ns
module rcla_top
    import rcla_pkg::*;
#(
    parameter logic [15:0] BIT_CLKS = 16'(BIT_CLKS_RESET)
) (
    // Clock and reset
    input  wire logic              REF_CLK,
    input  wire logic              RESETN,
    // APB slave
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [ADDR_W-1:0] PADDR,
    input  wire logic [31:0]       PWDATA,
    input  wire logic [3:0]        PSTRB,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    // Receive datapath
    input  wire logic              RX_BIT,
    input  wire logic              FRAME_SYNC_DET,
    // Acquisition outputs
    output logic      [2:0]        LEVEL_MODE,
    output logic      [1:0]        CLOCK_LOOP_BW,
    output logic                   BIT_TICK,
    output logic                   TIMING_UPDATE,
    output logic                   LEVEL_UPDATE
);

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    logic                 setup;
    logic                 access;
    logic                 addr_hit;
    logic                 wr_en;
    logic                 lev_cmd;
    logic                 bc_cmd;
    logic                 task_cmd;
    logic [1:0]           residual_level_mode;
    logic [1:0]           clock_loop_bandwidth;
    logic [BIT_DIV_W-1:0] bit_div;
    logic [1:0]           next_residual_level_mode;
    logic [1:0]           next_clock_loop_bandwidth;
    logic [BIT_DIV_W-1:0] next_bit_div;
    logic [31:0]          next_prdata;
    rcla_status_t         status;

    assign setup    = PSEL && !PENABLE;
    assign access   = PSEL && PENABLE;
    assign addr_hit = (PADDR == OFF_CMD) || (PADDR == OFF_CFG) ||
                      (PADDR == OFF_BITDIV) || (PADDR == OFF_STATUS);
    assign wr_en    = access && PWRITE && addr_hit;
    assign PREADY   = 1'b1;
    assign PSLVERR  = access && !addr_hit;

    // Commands take effect at the access edge of the write
    assign lev_cmd  = wr_en && (PADDR == OFF_CMD) && PSTRB[0] && PWDATA[CMD_LEV_POS];
    assign bc_cmd   = wr_en && (PADDR == OFF_CMD) && PSTRB[0] && PWDATA[CMD_BC_POS];
    assign task_cmd = wr_en && (PADDR == OFF_CMD) && PSTRB[0] &&
                      (PWDATA[CMD_SFH_POS] || PWDATA[CMD_SFS_POS]);

    always_comb begin
        next_residual_level_mode  = residual_level_mode;
        next_clock_loop_bandwidth = clock_loop_bandwidth;
        next_bit_div              = bit_div;
        next_prdata               = PRDATA;
        if (wr_en && (PADDR == OFF_CFG) && PSTRB[0]) begin
            next_residual_level_mode  = PWDATA[CFG_LEV_POS +: 2];
            next_clock_loop_bandwidth = PWDATA[CFG_BW_POS +: 2];
        end
        if (wr_en && (PADDR == OFF_BITDIV)) begin
            if (PSTRB[0]) begin
                next_bit_div[7:0] = PWDATA[7:0];
            end
            if (PSTRB[1]) begin
                next_bit_div[15:8] = PWDATA[15:8];
            end
        end
        // Read data is captured in setup so it can come from a flop
        if (setup && !PWRITE) begin
            next_prdata = 32'h0;
            case (PADDR)
                OFF_CFG: begin
                    next_prdata[CFG_LEV_POS +: 2] = residual_level_mode;
                    next_prdata[CFG_BW_POS +: 2]  = clock_loop_bandwidth;
                end
                OFF_BITDIV: begin
                    next_prdata[BIT_DIV_W-1:0] = bit_div;
                end
                OFF_STATUS: begin
                    next_prdata[$bits(rcla_status_t)-1:0] = status;
                end
                default: begin
                    next_prdata = 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            residual_level_mode  <= CFG_LEV_RESET;
            clock_loop_bandwidth <= CFG_BW_RESET;
            bit_div              <= 16'(BIT_CLKS_RESET);
            PRDATA               <= 32'h0;
        end else begin
            residual_level_mode  <= next_residual_level_mode;
            clock_loop_bandwidth <= next_clock_loop_bandwidth;
            bit_div              <= next_bit_div;
            PRDATA               <= next_prdata;
        end
    end

    // ----------------------------------------------------------------
    // Bit period timebase and receive bit watch
    // ----------------------------------------------------------------
    logic [BIT_DIV_W-1:0] div_cnt;
    logic [BIT_DIV_W-1:0] next_div_cnt;
    logic [BIT_DIV_W-1:0] div_eff;
    logic                 tick;
    logic                 rx_meta;
    logic                 rx_sync;
    logic                 rx_prev;
    logic                 bit_last;
    logic                 pair_armed;
    logic                 next_bit_last;
    logic                 next_pair_armed;
    logic                 next_level_update;

    // Tiny divisors would make a tick every cycle and break pair checks
    assign div_eff = (bit_div < BIT_DIV_MIN) ? BIT_DIV_MIN : bit_div;
    assign tick    = (div_cnt >= div_eff - 16'h0001);

    always_comb begin
        next_div_cnt      = tick ? 16'h0000 : div_cnt + 16'h0001;
        next_bit_last     = bit_last;
        next_pair_armed   = pair_armed;
        next_level_update = 1'b0;
        if (tick) begin
            next_bit_last = rx_sync;
            // Each equal pair is used once; long runs update only every pair
            if (pair_armed && (rx_sync == bit_last)) begin
                next_level_update = 1'b1;
                next_pair_armed   = 1'b0;
            end else begin
                next_pair_armed = 1'b1;
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            div_cnt       <= 16'h0000;
            rx_meta       <= 1'b0;
            rx_sync       <= 1'b0;
            rx_prev       <= 1'b0;
            bit_last      <= 1'b0;
            pair_armed    <= 1'b0;
            BIT_TICK      <= 1'b0;
            TIMING_UPDATE <= 1'b0;
            LEVEL_UPDATE  <= 1'b0;
        end else begin
            div_cnt       <= next_div_cnt;
            rx_meta       <= RX_BIT;
            rx_sync       <= rx_meta;
            rx_prev       <= rx_sync;
            bit_last      <= next_bit_last;
            pair_armed    <= next_pair_armed;
            BIT_TICK      <= tick;
            TIMING_UPDATE <= (rx_sync != rx_prev);
            LEVEL_UPDATE  <= next_level_update;
        end
    end

    // ----------------------------------------------------------------
    // Level acquisition sequencer
    // ----------------------------------------------------------------
    rcla_lev_state_t      lev_state;
    rcla_lev_state_t      next_lev_state;
    logic [BIT_CNT_W-1:0] lev_cnt;
    logic [BIT_CNT_W-1:0] next_lev_cnt;
    logic [BIT_CNT_W-1:0] lev_inc;
    logic                 lev_search;
    logic                 next_lev_search;
    logic [2:0]           next_level_mode;

    // Saturates so a long search cannot wrap into a false window
    assign lev_inc = (lev_cnt == CNT_MAX) ? lev_cnt : lev_cnt + 6'h01;

    always_comb begin
        next_lev_state  = lev_state;
        next_lev_cnt    = lev_cnt;
        next_lev_search = lev_search;
        if (lev_cmd) begin
            next_lev_state  = LS_CLAMP;
            next_lev_cnt    = 6'h00;
            next_lev_search = task_cmd;
        end else begin
            if (task_cmd && (lev_state != LS_RESID) && (lev_cnt <= LEV_SRCH_BITS)) begin
                next_lev_search = 1'b1;
            end
            if (tick) begin
                next_lev_cnt = lev_inc;
            end
            case (lev_state)
                LS_CLAMP: begin
                    if (tick && (lev_inc >= LEV_CLAMP_BITS)) begin
                        next_lev_state = LS_LOSSY;
                    end
                end
                LS_LOSSY: begin
                    if (next_lev_search) begin
                        if (FRAME_SYNC_DET) begin
                            next_lev_state = LS_RESID;
                        end
                    end else if (tick && (lev_inc >= LEV_RESID_BITS)) begin
                        next_lev_state = LS_RESID;
                    end
                end
                default: begin
                    next_lev_search = 1'b0;
                end
            endcase
        end
        case (next_lev_state)
            LS_CLAMP: next_level_mode = LVL_CLAMP;
            LS_LOSSY: next_level_mode = {1'b0, LEV_LOSSY};
            default:  next_level_mode = {1'b0, next_residual_level_mode};
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            lev_state  <= LS_RESID;
            lev_cnt    <= 6'h00;
            lev_search <= 1'b0;
            LEVEL_MODE <= {1'b0, CFG_LEV_RESET};
        end else begin
            lev_state  <= next_lev_state;
            lev_cnt    <= next_lev_cnt;
            lev_search <= next_lev_search;
            LEVEL_MODE <= next_level_mode;
        end
    end

    // ----------------------------------------------------------------
    // Bit clock acquisition sequencer
    // ----------------------------------------------------------------
    rcla_bc_state_t       bc_state;
    rcla_bc_state_t       next_bc_state;
    logic [BIT_CNT_W-1:0] bc_cnt;
    logic [BIT_CNT_W-1:0] next_bc_cnt;
    logic [BIT_CNT_W-1:0] bc_inc;
    logic                 bc_search;
    logic                 next_bc_search;
    logic [1:0]           next_loop_bw;

    assign bc_inc = (bc_cnt == CNT_MAX) ? bc_cnt : bc_cnt + 6'h01;

    always_comb begin
        next_bc_state  = bc_state;
        next_bc_cnt    = bc_cnt;
        next_bc_search = bc_search;
        if (bc_cmd) begin
            next_bc_state  = BS_WIDE;
            next_bc_cnt    = 6'h00;
            next_bc_search = task_cmd;
        end else begin
            if (tick) begin
                next_bc_cnt = bc_inc;
            end
            case (bc_state)
                BS_WIDE: begin
                    if (task_cmd && (bc_cnt <= BC_SRCH_BITS)) begin
                        next_bc_search = 1'b1;
                    end
                    if (next_bc_search) begin
                        if (FRAME_SYNC_DET) begin
                            next_bc_state  = BS_MEDIUM;
                            next_bc_cnt    = 6'h00;
                            next_bc_search = 1'b0;
                        end
                    end else if (tick && (bc_inc >= BC_WIDE_BITS)) begin
                        next_bc_state = BS_MEDIUM;
                        next_bc_cnt   = 6'h00;
                    end
                end
                BS_MEDIUM: begin
                    if (tick && (bc_inc >= BC_MED_BITS)) begin
                        next_bc_state = BS_RESID;
                    end
                end
                default: begin
                    next_bc_search = 1'b0;
                end
            endcase
        end
        case (next_bc_state)
            BS_WIDE:   next_loop_bw = BW_WIDE;
            BS_MEDIUM: next_loop_bw = BW_MEDIUM;
            default:   next_loop_bw = next_clock_loop_bandwidth;
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            bc_state      <= BS_RESID;
            bc_cnt        <= 6'h00;
            bc_search     <= 1'b0;
            CLOCK_LOOP_BW <= CFG_BW_RESET;
        end else begin
            bc_state      <= next_bc_state;
            bc_cnt        <= next_bc_cnt;
            bc_search     <= next_bc_search;
            CLOCK_LOOP_BW <= next_loop_bw;
        end
    end

    // ----------------------------------------------------------------
    // Status view
    // ----------------------------------------------------------------
    always_comb begin
        status.bc_phase   = bc_state;
        status.bc_search  = bc_search;
        status.lev_phase  = lev_state;
        status.lev_search = lev_search;
        status.loop_bw    = CLOCK_LOOP_BW;
        status.level_mode = LEVEL_MODE;
    end

endmodule

//--- verification/rcla_chk.sv
`timescale 1ns/1ns
module rcla_chk
    import rcla_pkg::*;
#(
    parameter logic [15:0] BIT_CLKS = 16'(BIT_CLKS_RESET)
) (
    // Clock and reset
    input wire logic              REF_CLK,
    input wire logic              RESETN,
    // APB
    input wire logic              PSEL,
    input wire logic              PENABLE,
    input wire logic              PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0]       PWDATA,
    input wire logic [3:0]        PSTRB,
    input wire logic [31:0]       PRDATA,
    input wire logic              PREADY,
    input wire logic              PSLVERR,
    // Datapath and acquisition
    input wire logic              RX_BIT,
    input wire logic              FRAME_SYNC_DET,
    input wire logic [2:0]        LEVEL_MODE,
    input wire logic [1:0]        CLOCK_LOOP_BW,
    input wire logic              BIT_TICK,
    input wire logic              TIMING_UPDATE
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    logic       acc;
    logic       wr_cmd;
    logic       wr_cfg;
    logic       rx_q;
    logic [3:0] quiet;
    assign acc    = PSEL && PENABLE;
    assign wr_cmd = acc && PWRITE && PADDR == OFF_CMD && PSTRB[0];
    assign wr_cfg = acc && PWRITE && PADDR == OFF_CFG;
    // Cycles since the pin last moved, saturating
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rx_q  <= 1'b0;
            quiet <= 4'hf;
        end else begin
            rx_q  <= RX_BIT;
            quiet <= (RX_BIT != rx_q) ? 4'h0 : ((quiet == 4'hf) ? quiet : quiet + 4'h1);
        end
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_clamp_first: assert property (wr_cmd && PWDATA[0] |=> LEVEL_MODE == LVL_CLAMP)
        else $error("level command did not start with clamp");
    a_clamp_then_lossy: assert property ($past(LEVEL_MODE) == LVL_CLAMP
        && LEVEL_MODE != LVL_CLAMP |-> LEVEL_MODE == {1'b0, LEV_LOSSY})
        else $error("clamp not followed by lossy peak detect");
    a_wide_first: assert property (wr_cmd && PWDATA[1] |=> CLOCK_LOOP_BW == BW_WIDE)
        else $error("clock command did not select wide bandwidth");
    a_wide_to_medium: assert property ($past(CLOCK_LOOP_BW) == BW_WIDE
        && CLOCK_LOOP_BW != BW_WIDE && !$past(wr_cfg) |-> CLOCK_LOOP_BW == BW_MEDIUM)
        else $error("wide bandwidth left for other than medium");
    a_medium_holds: assert property ($rose(CLOCK_LOOP_BW == BW_MEDIUM)
        |-> (CLOCK_LOOP_BW == BW_MEDIUM) [*8])
        else $error("medium bandwidth held too briefly");
    a_tick_single: assert property (BIT_TICK |=> !BIT_TICK)
        else $error("bit tick longer than one cycle");
    a_timing_on_edge: assert property (TIMING_UPDATE |-> quiet < 4'h6)
        else $error("timing update without a data transition");
    a_zero_wait: assert property (acc |-> PREADY)
        else $error("ready low in access phase");
    a_err_unmapped: assert property (acc && PADDR[1:0] == 2'h0
        |-> PSLVERR == (PADDR > OFF_STATUS))
        else $error("slave error does not match address map");
    a_cmd_reads_zero: assert property (PSEL && !PENABLE && !PWRITE && PADDR == OFF_CMD
        |=> PRDATA == 32'h0)
        else $error("command register read not zero");
    c_clamp: cover property (LEVEL_MODE == LVL_CLAMP);
    c_sync_wide: cover property (FRAME_SYNC_DET && CLOCK_LOOP_BW == BW_WIDE);
    c_slverr: cover property (PSLVERR);
    c_timing: cover property (TIMING_UPDATE);
endmodule

//--- verification/rcla_host.sv
`timescale 1ns/1ns
module rcla_host
    import rcla_pkg::*;
(
    // Clock
    input wire logic              clk,
    // APB master
    output logic                  psel,
    output logic                  penable,
    output logic                  pwrite,
    output logic [ADDR_W-1:0]     paddr,
    output logic [31:0]           pwdata,
    output logic [3:0]            pstrb,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'hff;
        pwdata  = 32'h0;
        pstrb   = 4'h0;
    end
    // Released bus shows inverted values so stale data never looks valid
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= 4'hf;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask
endmodule

//--- verification/tb.sv
`timescale 1ns/1ns
module tb;
    import rcla_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic rx_bit = 1'b0;
    logic frame_sync_det = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, bit_tick, timing_update, level_update;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] pstrb;
    logic [2:0] level_mode;
    logic [1:0] clock_loop_bw;
    logic e;
    int n_errors = 0;
    int compares = 0;
    int cycles = 0;
    int n, m;
    always #4 ref_clk = ~ref_clk;
    rcla_host i_rcla_host (.clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    rcla_top #(.BIT_CLKS(16'h0004)) i_rcla_top (.REF_CLK(ref_clk), .RESETN(resetn),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .RX_BIT(rx_bit),
        .FRAME_SYNC_DET(frame_sync_det), .LEVEL_MODE(level_mode),
        .CLOCK_LOOP_BW(clock_loop_bw), .BIT_TICK(bit_tick), .TIMING_UPDATE(timing_update),
        .LEVEL_UPDATE(level_update));
    // ------------------------------------------------------------
    // Checks and helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_rcla_host.xfer(1'b1, a, d, q, e);
    endtask
    task automatic ticks(input int k);
        repeat (k) begin
            @(posedge ref_clk);
            while (bit_tick !== 1'b1) @(posedge ref_clk);
        end
    endtask
    // Counts bit ticks until the chosen output shows the wanted value
    task automatic count_to(input logic bw, input logic [2:0] want, output int k);
        k = 0;
        for (int i = 0; i < 400; i++) begin
            @(posedge ref_clk);
            #1;
            k += (bit_tick === 1'b1);
            if ((bw ? {1'b0, clock_loop_bw} : level_mode) === want) break;
        end
    endtask
    task automatic sync_pulse();
        @(posedge ref_clk);
        frame_sync_det <= 1'b1;
        @(posedge ref_clk);
        frame_sync_det <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        i_rcla_host.xfer(1'b0, OFF_CFG, 32'h0, q, e);
        chk(q, 32'h20);
        i_rcla_host.xfer(1'b0, OFF_BITDIV, 32'h0, q, e);
        chk(q, 32'h3d09);
        i_rcla_host.xfer(1'b0, 8'h40, 32'h0, q, e);
        chk(q, 32'h0);
        chk({31'h0, e}, 32'h1);
        wr(OFF_BITDIV, 32'h4);
        wr(OFF_CFG, 32'h31);
        i_rcla_host.xfer(1'b0, OFF_CMD, 32'h0, q, e);
        chk(q, 32'h0);
        $display("test regs done");
    endtask
    task automatic t_timed();
        // Carrier seen, filter delay allowed for
        ticks(2);
        wr(OFF_CMD, 32'h1);
        // Clamp may last only until the next tick, so look at once
        #1;
        chk(level_mode, LVL_CLAMP);
        count_to(1'b0, 3'h0, n);
        chk(n >= 1 && n <= 2, 1'b1);
        count_to(1'b0, 3'h1, m);
        chk(n + m >= 29 && n + m <= 31, 1'b1);
        wr(OFF_CMD, 32'h2);
        @(posedge ref_clk);
        #1;
        chk(clock_loop_bw, BW_WIDE);
        count_to(1'b1, 3'h1, n);
        chk(n >= 15 && n <= 17, 1'b1);
        count_to(1'b1, 3'h3, n);
        chk(n >= 29 && n <= 31, 1'b1);
        $display("test timed done");
    endtask
    task automatic t_search();
        wr(OFF_CMD, 32'hb);
        ticks(40);
        #1;
        chk({level_mode, clock_loop_bw}, {3'h0, BW_WIDE});
        i_rcla_host.xfer(1'b0, OFF_STATUS, 32'h0, q, e);
        chk(q, 32'h3a0);
        sync_pulse();
        chk({level_mode, clock_loop_bw}, {3'h1, BW_MEDIUM});
        count_to(1'b1, 3'h3, n);
        chk(n >= 28 && n <= 31, 1'b1);
        $display("test search done");
    endtask
    task automatic t_late();
        wr(OFF_CMD, 32'h3);
        ticks(20);
        wr(OFF_CMD, 32'h4);
        ticks(15);
        #1;
        chk({level_mode, clock_loop_bw}, {3'h0, BW_MEDIUM});
        sync_pulse();
        chk(level_mode, 3'h1);
        count_to(1'b1, 3'h3, n);
        chk({1'b0, clock_loop_bw}, 3'h3);
        chk(n >= 1 && n <= 14, 1'b1);
        $display("test late done");
    endtask
    task automatic t_resid();
        for (int v = 0; v < 4; v++) begin
            wr(OFF_CFG, 32'(v) | (32'(v) << 4));
            repeat (10) @(posedge ref_clk);
            #1;
            chk({level_mode, clock_loop_bw}, {1'b0, 2'(v), 2'(v)});
        end
        // Hold only briefly, as during a fade
        wr(OFF_CFG, 32'h31);
        $display("test resid done");
    endtask
    task automatic t_edges(input logic alt);
        n = 0;
        m = 0;
        for (int i = 0; i < 64; i++) begin
            @(posedge ref_clk);
            if (alt && bit_tick === 1'b1) rx_bit <= ~rx_bit;
            #1;
            n += (i > 16 && timing_update === 1'b1);
            m += (i > 16 && level_update === 1'b1);
        end
        chk({n > 0, m > 0}, {alt, !alt});
        $display("test edges done");
    endtask
    task automatic wrap_up();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            wrap_up();
        end
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        t_regs();
        t_timed();
        t_search();
        t_late();
        t_resid();
        t_edges(1'b0);
        t_edges(1'b1);
        wrap_up();
    end
endmodule
bind rcla_top rcla_chk #(.BIT_CLKS(BIT_CLKS)) i_rcla_chk (.REF_CLK(REF_CLK),
    .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .RX_BIT(RX_BIT), .FRAME_SYNC_DET(FRAME_SYNC_DET), .LEVEL_MODE(LEVEL_MODE),
    .CLOCK_LOOP_BW(CLOCK_LOOP_BW), .BIT_TICK(BIT_TICK), .TIMING_UPDATE(TIMING_UPDATE));
